// [rph_pkg.sv]
// Constants, types and helpers shared by the radio packet handler
package rph_pkg;

	// ****************************************
	// Register byte addresses
	// ****************************************
	localparam logic [7:0] RPH_A_SYNC_HI   = 8'h00;
	localparam logic [7:0] RPH_A_SYNC_LO   = 8'h04;
	localparam logic [7:0] RPH_A_PACKET_LENGTH_REG    = 8'h08;
	localparam logic [7:0] RPH_A_CTRL_MAIN = 8'h0C;
	localparam logic [7:0] RPH_A_CTRL_FILT = 8'h10;
	localparam logic [7:0] RPH_A_NODE      = 8'h14;
	localparam logic [7:0] RPH_A_MDM_ONE   = 8'h18;
	localparam logic [7:0] RPH_A_MDM_TWO   = 8'h1C;
	localparam logic [7:0] RPH_A_SM_CFG    = 8'h20;
	localparam logic [7:0] RPH_A_CMD       = 8'h24;
	localparam logic [7:0] RPH_A_STATUS    = 8'h28;
	localparam logic [7:0] RPH_A_BAUD      = 8'h2C;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0]  RPH_RST_SYNC_HI   = 8'h5A;
	localparam logic [7:0]  RPH_RST_SYNC_LO   = 8'hC3;
	localparam logic [7:0]  RPH_RST_PACKET_LENGTH_REG    = 8'hFF;
	localparam logic [7:0]  RPH_RST_CTRL_MAIN = 8'h05;
	localparam logic [7:0]  RPH_RST_CTRL_FILT = 8'h04;
	localparam logic [7:0]  RPH_RST_NODE      = 8'h00;
	localparam logic [7:0]  RPH_RST_MDM_ONE   = 8'h03;
	localparam logic [7:0]  RPH_RST_MDM_TWO   = 8'h02;
	localparam logic [7:0]  RPH_RST_SM_CFG    = 8'h00;
	localparam logic [15:0] RPH_RST_BAUD      = 16'h00F9;

	// ****************************************
	// Field positions and encodings
	// ****************************************
	localparam int RPH_CRC_EN_BIT   = 2;
	localparam int RPH_APPEND_BIT   = 2;
	localparam int RPH_AFLUSH_BIT   = 3;
	localparam int RPH_TXOFF_LSB    = 2;
	localparam int RPH_CMD_TX       = 0;
	localparam int RPH_CMD_RX       = 1;
	localparam int RPH_CMD_IDLE     = 2;
	localparam int RPH_CMD_FLUSH_TX = 3;
	localparam int RPH_CMD_FLUSH_RX = 4;
	localparam int RPH_CRC_OK_BIT   = 7;
	localparam logic [1:0] RPH_LEN_FIXED = 2'h0;
	localparam logic [1:0] RPH_LEN_VAR   = 2'h1;
	localparam logic [1:0] RPH_LEN_INF   = 2'h2;
	localparam logic [1:0] RPH_ADR_ALL   = 2'h3;
	localparam logic [2:0] RPH_SYNC_NONE = 3'h0;
	localparam logic [2:0] RPH_SYNC_DUPA = 3'h3;
	localparam logic [2:0] RPH_SYNC_DUPB = 3'h7;
	localparam logic [1:0] RPH_EXIT_TX   = 2'h2;
	localparam logic [1:0] RPH_EXIT_RX   = 2'h3;
	localparam logic [7:0] RPH_PREAMBLE  = 8'hAA;
	localparam logic [7:0] RPH_BCAST_LO  = 8'h00;
	localparam logic [7:0] RPH_BCAST_HI  = 8'hFF;
	localparam logic [7:0] RPH_INF_MARK  = 8'hFF;
	localparam logic [15:0] RPH_CRC_POLY = 16'h8005;
	localparam logic [15:0] RPH_CRC_INIT = 16'hFFFF;

	// ****************************************
	// Types
	// ****************************************
	typedef enum {RPH_IDLE, RPH_RX, RPH_TX} rph_radio_t;
	typedef enum {T_IDLE, T_PRE, T_SYNC, T_WAIT, T_DATA, T_CRC, T_TAIL, T_UNDER} rph_tx_st_t;
	typedef enum {R_IDLE, R_HUNT, R_LEN, R_ADDR, R_DATA, R_CRC, R_CHK, R_ST1, R_ST2, R_FIN} rph_rx_st_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} rph_byte_t;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic rph_radio_t rph_exit_state(input logic [1:0] mode);
		if (mode == RPH_EXIT_TX) begin
			return RPH_TX;
		end else if (mode == RPH_EXIT_RX) begin
			return RPH_RX;
		end
		return RPH_IDLE;
	endfunction

	function automatic logic rph_sync32(input logic [2:0] mode);
		return (mode == RPH_SYNC_DUPA) || (mode == RPH_SYNC_DUPB);
	endfunction

endpackage

// [rph_crc16.sv]
// Bytewise CRC-16 accumulator, MSB first
`timescale 1ns/1ps
module rph_crc16 (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Byte stream
	input  wire logic        clr_i,
	input  wire logic        en_i,
	input  wire logic [7:0]  byte_i,
	output logic      [15:0] crc_o
);
	logic [15:0] next_crc;

	always_comb begin
		next_crc = crc_o;
		for (int i = 7; i >= 0; i--) begin
			if (next_crc[15] ^ byte_i[i]) begin
				next_crc = {next_crc[14:0], 1'b0} ^ rph_pkg::RPH_CRC_POLY;
			end else begin
				next_crc = {next_crc[14:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || clr_i) begin
			crc_o <= rph_pkg::RPH_CRC_INIT;
		end else if (en_i) begin
			crc_o <= next_crc;
		end
	end
endmodule

// [rph_top.sv]
// Radio packet handler: register slave, transmit framer and receive deframer
//
// The Wishbone register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module rph_top (
	// Clock and reset
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	// Wishbone slave
	input  wire logic               wb_cyc_i,
	input  wire logic               wb_stb_i,
	input  wire logic               wb_we_i,
	input  wire logic [7:0]         wb_adr_i,
	input  wire logic [3:0]         wb_sel_i,
	input  wire logic [31:0]        wb_dat_i,
	output logic                    wb_ack_o,
	output logic      [31:0]        wb_dat_o,
	// Transmit FIFO read side
	input  wire rph_pkg::rph_byte_t tx_byte_i,
	output logic                    tx_pop_o,
	output logic                    tx_flush_o,
	// Receive FIFO write side
	output rph_pkg::rph_byte_t      rx_wr_o,
	output logic                    rx_flush_o,
	// Modem bit streams
	output logic                    mod_bit_o,
	output logic                    mod_en_o,
	output logic                    mod_tick_o,
	input  wire logic               dem_bit_i,
	input  wire logic               dem_valid_i,
	input  wire logic [7:0]         rssi_i
);
	// ****************************************
	// Declarations
	// ****************************************
	logic [7:0]  sync_word_high;
	logic [7:0]  sync_word_low;
	logic [7:0]  packet_length_reg;
	logic [7:0]  packet_control_main;
	logic [7:0]  packet_control_filter;
	logic [7:0]  node_addr;
	logic [7:0]  modem_config_one;
	logic [7:0]  modem_config_two;
	logic [7:0]  state_machine_config;
	logic [15:0] baud_div;
	logic [15:0] baud_cnt;
	logic        tick;
	logic        req;
	logic        wr_go;
	logic [4:0]  cmd;
	logic [31:0] next_rd;
	logic [1:0]  len_cfg;
	logic [1:0]  address_check_field;
	logic [1:0]  receive_exit_mode;
	logic [1:0]  transmit_exit_mode;
	logic        crc_en;
	logic        framed;
	rph_pkg::rph_radio_t radio;
	rph_pkg::rph_tx_st_t tx_st;
	rph_pkg::rph_rx_st_t rx_st;
	logic [7:0]  tx_sh;
	logic [2:0]  tx_bit;
	logic [7:0]  tx_cnt;
	logic [7:0]  tx_len;
	logic [2:0]  tx_pre;
	logic [1:0]  tx_sidx;
	logic [1:0]  sync_last;
	logic        tx_first;
	logic        tx_under;
	logic        tx_done;
	logic        tx_end;
	logic        tx_take;
	logic [15:0] tx_crc;
	logic [7:0]  rx_sh;
	logic [2:0]  rx_bit;
	logic [31:0] rx_hunt;
	logic [31:0] next_hunt;
	logic [7:0]  rx_byte;
	logic        rx_bv;
	logic        rx_hit;
	logic [7:0]  rx_cnt;
	logic [7:0]  next_rx_cnt;
	logic [7:0]  rx_len;
	logic        rx_end;
	logic        rx_adr_ok;
	logic        rx_sidx;
	logic        rx_ok;
	logic        rx_pend;
	logic [7:0]  rx_pend_data;
	logic        rx_done;
	logic        rx_crc_clr;
	logic [15:0] rx_crc;
	rph_pkg::rph_rx_st_t rx_head;
	rph_pkg::rph_rx_st_t rx_after_len;
	rph_pkg::rph_rx_st_t rx_tail;

	assign len_cfg             = packet_control_main[1:0];
	assign crc_en              = packet_control_main[rph_pkg::RPH_CRC_EN_BIT];
	assign address_check_field = packet_control_filter[1:0];
	assign receive_exit_mode   = state_machine_config[1:0];
	assign transmit_exit_mode  = state_machine_config[rph_pkg::RPH_TXOFF_LSB +: 2];
	assign framed              = modem_config_two[2:0] != rph_pkg::RPH_SYNC_NONE;
	assign sync_last           = rph_pkg::rph_sync32(modem_config_two[2:0]) ? 2'h3 : 2'h1;

	// ****************************************
	// Wishbone slave and registers
	// ****************************************
	assign req   = wb_cyc_i & wb_stb_i;
	assign wr_go = req & wb_we_i & wb_ack_o;
	assign cmd   = (wr_go && wb_sel_i[0] && wb_adr_i == rph_pkg::RPH_A_CMD) ? wb_dat_i[4:0] : 5'h00;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req & ~wb_ack_o;
			if (req && !wb_ack_o) begin
				wb_dat_o <= next_rd;
			end
		end
	end

	always_comb begin
		next_rd = 32'h0000_0000;
		case (wb_adr_i)
			rph_pkg::RPH_A_SYNC_HI:   next_rd[7:0] = sync_word_high;
			rph_pkg::RPH_A_SYNC_LO:   next_rd[7:0] = sync_word_low;
			rph_pkg::RPH_A_PACKET_LENGTH_REG:    next_rd[7:0] = packet_length_reg;
			rph_pkg::RPH_A_CTRL_MAIN: next_rd[7:0] = packet_control_main;
			rph_pkg::RPH_A_CTRL_FILT: next_rd[7:0] = packet_control_filter;
			rph_pkg::RPH_A_NODE:      next_rd[7:0] = node_addr;
			rph_pkg::RPH_A_MDM_ONE:   next_rd[7:0] = modem_config_one;
			rph_pkg::RPH_A_MDM_TWO:   next_rd[7:0] = modem_config_two;
			rph_pkg::RPH_A_SM_CFG:    next_rd[7:0] = state_machine_config;
			rph_pkg::RPH_A_BAUD:      next_rd[15:0] = baud_div;
			rph_pkg::RPH_A_STATUS: begin
				next_rd[0]    = radio == rph_pkg::RPH_RX;
				next_rd[1]    = radio == rph_pkg::RPH_TX;
				next_rd[2]    = tx_under;
				next_rd[3]    = rx_ok;
				next_rd[15:8] = rx_cnt;
			end
			default:                  next_rd = 32'h0000_0000;
		endcase
	end

	// Configuration may be rewritten at any time, also mid-packet
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync_word_high        <= rph_pkg::RPH_RST_SYNC_HI;
			sync_word_low         <= rph_pkg::RPH_RST_SYNC_LO;
			packet_length_reg     <= rph_pkg::RPH_RST_PACKET_LENGTH_REG;
			packet_control_main   <= rph_pkg::RPH_RST_CTRL_MAIN;
			packet_control_filter <= rph_pkg::RPH_RST_CTRL_FILT;
			node_addr             <= rph_pkg::RPH_RST_NODE;
			modem_config_one      <= rph_pkg::RPH_RST_MDM_ONE;
			modem_config_two      <= rph_pkg::RPH_RST_MDM_TWO;
			state_machine_config  <= rph_pkg::RPH_RST_SM_CFG;
			baud_div              <= rph_pkg::RPH_RST_BAUD;
		end else if (wr_go) begin
			if (wb_sel_i[0]) begin
				case (wb_adr_i)
					rph_pkg::RPH_A_SYNC_HI:   sync_word_high <= wb_dat_i[7:0];
					rph_pkg::RPH_A_SYNC_LO:   sync_word_low <= wb_dat_i[7:0];
					rph_pkg::RPH_A_PACKET_LENGTH_REG:    packet_length_reg <= wb_dat_i[7:0];
					rph_pkg::RPH_A_CTRL_MAIN: packet_control_main <= wb_dat_i[7:0];
					rph_pkg::RPH_A_CTRL_FILT: packet_control_filter <= wb_dat_i[7:0];
					rph_pkg::RPH_A_NODE:      node_addr <= wb_dat_i[7:0];
					rph_pkg::RPH_A_MDM_ONE:   modem_config_one <= wb_dat_i[7:0];
					rph_pkg::RPH_A_MDM_TWO:   modem_config_two <= wb_dat_i[7:0];
					rph_pkg::RPH_A_SM_CFG:    state_machine_config <= wb_dat_i[7:0];
					rph_pkg::RPH_A_BAUD:      baud_div[7:0] <= wb_dat_i[7:0];
					default:                  baud_div <= baud_div;
				endcase
			end
			if (wb_sel_i[1] && wb_adr_i == rph_pkg::RPH_A_BAUD) begin
				baud_div[15:8] <= wb_dat_i[15:8];
			end
		end
	end

	// ****************************************
	// Bit rate divider and radio state
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			baud_cnt   <= 16'h0000;
			tick       <= 1'b0;
			mod_tick_o <= 1'b0;
		end else begin
			tick       <= baud_cnt == 16'h0000;
			baud_cnt   <= (baud_cnt == 16'h0000) ? baud_div : baud_cnt - 16'h0001;
			// Marks only the ticks that launch a new bit
			mod_tick_o <= tick && radio == rph_pkg::RPH_TX
				&& tx_st inside {rph_pkg::T_PRE, rph_pkg::T_SYNC, rph_pkg::T_DATA, rph_pkg::T_CRC};
		end
	end

	// An underflowed transmitter holds the radio until the flush strobe
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			radio <= rph_pkg::RPH_IDLE;
		end else if (tx_under) begin
			if (cmd[rph_pkg::RPH_CMD_FLUSH_TX]) begin
				radio <= rph_pkg::RPH_IDLE;
			end
		end else if (cmd[rph_pkg::RPH_CMD_IDLE]) begin
			radio <= rph_pkg::RPH_IDLE;
		end else if (cmd[rph_pkg::RPH_CMD_TX]) begin
			radio <= rph_pkg::RPH_TX;
		end else if (cmd[rph_pkg::RPH_CMD_RX]) begin
			radio <= rph_pkg::RPH_RX;
		end else if (tx_done) begin
			radio <= rph_pkg::rph_exit_state(transmit_exit_mode);
		end else if (rx_done) begin
			radio <= rph_pkg::rph_exit_state(receive_exit_mode);
		end
	end

	// ****************************************
	// Transmit framer
	// ****************************************
	rph_crc16 u_tx_crc (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.clr_i  (tx_st == rph_pkg::T_IDLE),
		.en_i   (tx_take && tx_byte_i.valid),
		.byte_i (tx_byte_i.data),
		.crc_o  (tx_crc)
	);

	always_comb begin
		tx_end = 1'b0;
		if (len_cfg == rph_pkg::RPH_LEN_FIXED) begin
			tx_end = tx_cnt == packet_length_reg;
		end else if (len_cfg == rph_pkg::RPH_LEN_VAR) begin
			tx_end = !tx_first && tx_cnt == tx_len;
		end
		tx_take = tick && (tx_st == rph_pkg::T_WAIT || (tx_bit == 3'h7
			&& ((tx_st == rph_pkg::T_SYNC && tx_sidx == sync_last) || (tx_st == rph_pkg::T_DATA && !tx_end))));
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_st      <= rph_pkg::T_IDLE;
			tx_sh      <= 8'h00;
			tx_bit     <= 3'h0;
			tx_cnt     <= 8'h00;
			tx_len     <= 8'h00;
			tx_pre     <= 3'h0;
			tx_sidx    <= 2'h0;
			tx_first   <= 1'b0;
			tx_under   <= 1'b0;
			tx_done    <= 1'b0;
			tx_pop_o   <= 1'b0;
			tx_flush_o <= 1'b0;
			mod_bit_o  <= 1'b0;
			mod_en_o   <= 1'b0;
		end else begin
			tx_pop_o   <= 1'b0;
			tx_done    <= 1'b0;
			tx_flush_o <= cmd[rph_pkg::RPH_CMD_FLUSH_TX];
			if (tx_st == rph_pkg::T_UNDER) begin
				if (cmd[rph_pkg::RPH_CMD_FLUSH_TX]) begin
					tx_under <= 1'b0;
					tx_st    <= rph_pkg::T_IDLE;
				end
			end else if (tx_st == rph_pkg::T_IDLE) begin
				if (radio == rph_pkg::RPH_TX && !tx_done) begin
					tx_cnt   <= 8'h00;
					tx_bit   <= 3'h0;
					tx_first <= len_cfg == rph_pkg::RPH_LEN_VAR;
					tx_sh    <= rph_pkg::RPH_PREAMBLE;
					tx_pre   <= modem_config_one[2:0];
					tx_st    <= framed ? rph_pkg::T_PRE : rph_pkg::T_WAIT;
					mod_en_o <= framed;
				end
			end else if (radio != rph_pkg::RPH_TX) begin
				tx_st    <= rph_pkg::T_IDLE;
				mod_en_o <= 1'b0;
			end else if (tx_take) begin
				if (tx_st != rph_pkg::T_WAIT) begin
					mod_bit_o <= tx_sh[7];
					tx_bit    <= tx_bit + 3'h1;
				end
				if (tx_byte_i.valid) begin
					tx_sh    <= tx_byte_i.data;
					tx_pop_o <= 1'b1;
					mod_en_o <= 1'b1;
					tx_st    <= rph_pkg::T_DATA;
					if (tx_first) begin
						tx_len   <= tx_byte_i.data;
						tx_first <= 1'b0;
					end else begin
						tx_cnt <= tx_cnt + 8'h01;
					end
				end else begin
					tx_st    <= rph_pkg::T_UNDER;
					tx_under <= 1'b1;
					mod_en_o <= 1'b0;
				end
			end else if (tick) begin
				if (tx_st == rph_pkg::T_TAIL) begin
					tx_st    <= rph_pkg::T_IDLE;
					mod_en_o <= 1'b0;
					tx_done  <= 1'b1;
				end else begin
					mod_bit_o <= tx_sh[7];
					tx_sh     <= {tx_sh[6:0], 1'b0};
					tx_bit    <= tx_bit + 3'h1;
					if (tx_bit == 3'h7) begin
						case (tx_st)
							rph_pkg::T_PRE: begin
								if (tx_pre != 3'h0) begin
									tx_pre <= tx_pre - 3'h1;
									tx_sh  <= rph_pkg::RPH_PREAMBLE;
								end else if (tx_byte_i.valid) begin
									tx_sh   <= sync_word_high;
									tx_sidx <= 2'h0;
									tx_st   <= rph_pkg::T_SYNC;
								end else begin
									tx_sh <= rph_pkg::RPH_PREAMBLE;
								end
							end
							rph_pkg::T_SYNC: begin
								tx_sidx <= tx_sidx + 2'h1;
								tx_sh   <= tx_sidx[0] ? sync_word_high : sync_word_low;
							end
							rph_pkg::T_DATA: begin
								if (crc_en) begin
									tx_sh   <= tx_crc[15:8];
									tx_sidx <= 2'h0;
									tx_st   <= rph_pkg::T_CRC;
								end else begin
									tx_st <= rph_pkg::T_TAIL;
								end
							end
							rph_pkg::T_CRC: begin
								if (tx_sidx == 2'h0) begin
									tx_sh   <= tx_crc[7:0];
									tx_sidx <= 2'h1;
								end else begin
									tx_st <= rph_pkg::T_TAIL;
								end
							end
							default: tx_st <= tx_st;
						endcase
					end
				end
			end
		end
	end

	// ****************************************
	// Receive deframer
	// ****************************************
	rph_crc16 u_rx_crc (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.clr_i  (rx_crc_clr),
		.en_i   (rx_bv),
		.byte_i (rx_byte),
		.crc_o  (rx_crc)
	);

	always_comb begin
		rx_byte      = {rx_sh[6:0], dem_bit_i};
		rx_bv        = dem_valid_i && rx_bit == 3'h7 && rx_st inside {rph_pkg::R_LEN, rph_pkg::R_ADDR,
			rph_pkg::R_DATA, rph_pkg::R_CRC};
		next_hunt    = {rx_hunt[30:0], dem_bit_i};
		rx_hit       = rph_pkg::rph_sync32(modem_config_two[2:0])
			? next_hunt == {sync_word_high, sync_word_low, sync_word_high, sync_word_low}
			: next_hunt[15:0] == {sync_word_high, sync_word_low};
		next_rx_cnt  = rx_cnt + 8'h01;
		rx_end       = (len_cfg == rph_pkg::RPH_LEN_FIXED && next_rx_cnt == packet_length_reg)
			|| (len_cfg == rph_pkg::RPH_LEN_VAR && next_rx_cnt == rx_len);
		rx_adr_ok    = rx_byte == node_addr
			|| (address_check_field[1] && rx_byte == rph_pkg::RPH_BCAST_LO)
			|| (address_check_field == rph_pkg::RPH_ADR_ALL && rx_byte == rph_pkg::RPH_BCAST_HI);
		rx_after_len = (address_check_field != 2'h0) ? rph_pkg::R_ADDR : rph_pkg::R_DATA;
		rx_head      = (len_cfg == rph_pkg::RPH_LEN_VAR) ? rph_pkg::R_LEN : rx_after_len;
		rx_tail      = crc_en ? rph_pkg::R_CRC : rph_pkg::R_CHK;
		rx_crc_clr   = (rx_st == rph_pkg::R_IDLE) || (rx_st == rph_pkg::R_HUNT && dem_valid_i && rx_hit);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_st        <= rph_pkg::R_IDLE;
			rx_sh        <= 8'h00;
			rx_bit       <= 3'h0;
			rx_hunt      <= 32'h0000_0000;
			rx_cnt       <= 8'h00;
			rx_len       <= 8'h00;
			rx_sidx      <= 1'b0;
			rx_ok        <= 1'b0;
			rx_pend      <= 1'b0;
			rx_pend_data <= 8'h00;
			rx_done      <= 1'b0;
			rx_wr_o      <= '0;
			rx_flush_o   <= 1'b0;
		end else begin
			rx_wr_o.valid <= 1'b0;
			rx_done       <= 1'b0;
			rx_flush_o    <= cmd[rph_pkg::RPH_CMD_FLUSH_RX];
			if (rx_st == rph_pkg::R_IDLE) begin
				if (radio == rph_pkg::RPH_RX && !rx_done) begin
					rx_st  <= framed ? rph_pkg::R_HUNT : rx_head;
					rx_bit <= 3'h0;
					rx_cnt <= 8'h00;
				end
			end else if (radio != rph_pkg::RPH_RX) begin
				rx_st   <= rph_pkg::R_IDLE;
				rx_pend <= 1'b0;
			end else begin
				case (rx_st)
					rph_pkg::R_HUNT: begin
						if (dem_valid_i) begin
							rx_hunt <= next_hunt;
							if (rx_hit) begin
								rx_st   <= rx_head;
								rx_bit  <= 3'h0;
								rx_cnt  <= 8'h00;
								rx_hunt <= 32'h0000_0000;
							end
						end
					end
					rph_pkg::R_CHK: begin
						rx_ok <= !crc_en || rx_crc == 16'h0000;
						rx_st <= packet_control_filter[rph_pkg::RPH_APPEND_BIT] ? rph_pkg::R_ST1 : rph_pkg::R_FIN;
					end
					rph_pkg::R_ST1: begin
						rx_wr_o <= '{valid: 1'b1, data: rssi_i};
						rx_st   <= rph_pkg::R_ST2;
					end
					rph_pkg::R_ST2: begin
						rx_wr_o <= '{valid: 1'b1, data: {rx_ok, 7'h00}};
						rx_st   <= rph_pkg::R_FIN;
					end
					rph_pkg::R_FIN: begin
						if (!rx_ok && packet_control_filter[rph_pkg::RPH_AFLUSH_BIT]) begin
							rx_flush_o <= 1'b1;
						end
						rx_done <= 1'b1;
						rx_st   <= rph_pkg::R_IDLE;
					end
					default: begin
						if (dem_valid_i) begin
							rx_sh  <= rx_byte;
							rx_bit <= rx_bit + 3'h1;
						end
						if (rx_pend) begin
							rx_wr_o <= '{valid: 1'b1, data: rx_pend_data};
							rx_pend <= 1'b0;
						end
						if (rx_bv) begin
							case (rx_st)
								rph_pkg::R_LEN: begin
									if (rx_byte > packet_length_reg) begin
										rx_st <= rph_pkg::R_HUNT;
									end else begin
										rx_wr_o <= '{valid: 1'b1, data: rx_byte};
										rx_len  <= rx_byte;
										rx_st   <= rx_after_len;
									end
								end
								rph_pkg::R_ADDR: begin
									if (!rx_adr_ok) begin
										rx_st <= rph_pkg::R_HUNT;
									end else begin
										rx_cnt <= next_rx_cnt;
										rx_st  <= rx_end ? rx_tail : rph_pkg::R_DATA;
										if (len_cfg == rph_pkg::RPH_LEN_INF) begin
											rx_wr_o      <= '{valid: 1'b1, data: rph_pkg::RPH_INF_MARK};
											rx_pend      <= 1'b1;
											rx_pend_data <= rx_byte;
										end else begin
											rx_wr_o <= '{valid: 1'b1, data: rx_byte};
										end
									end
								end
								rph_pkg::R_DATA: begin
									rx_wr_o <= '{valid: 1'b1, data: rx_byte};
									rx_cnt  <= next_rx_cnt;
									if (rx_end) begin
										rx_st   <= rx_tail;
										rx_sidx <= 1'b0;
									end
								end
								rph_pkg::R_CRC: begin
									rx_sidx <= 1'b1;
									if (rx_sidx) begin
										rx_st <= rph_pkg::R_CHK;
									end
								end
								default: rx_st <= rx_st;
							endcase
						end
					end
				endcase
			end
		end
	end
endmodule

// [rph_fifo_model.sv]
// Transmit FIFO model, first-word-fall-through head
`timescale 1ns/1ps
module rph_fifo_model (
	// Clock, bench push and design side
	input  wire logic          clk_i,
	input  wire logic          push_i,
	input  wire logic [7:0]    data_i,
	input  wire logic          pop_i,
	input  wire logic          flush_i,
	output rph_pkg::rph_byte_t head_o
);
	logic [7:0] q[$];
	always @(posedge clk_i) begin
		if (flush_i === 1'b1) begin
			q.delete();
		end else begin
			if (pop_i === 1'b1 && q.size() > 0) void'(q.pop_front());
			if (push_i) q.push_back(data_i);
		end
	end
	always_comb begin
		head_o.valid = q.size() > 0;
		head_o.data = (q.size() > 0) ? q[0] : 8'h00;
	end
endmodule

// [rph_properties.sv]
// Port checks for the packet handler
`timescale 1ns/1ps
module rph_properties (
	// Clock, bus and stream ports
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic        wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	input wire logic        tx_pop_o,
	input wire logic        tx_flush_o,
	input wire logic        rx_flush_o,
	input wire logic        mod_bit_o,
	input wire logic        mod_en_o,
	input wire logic        mod_tick_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire cmd = wb_ack_o && wb_we_i && wb_adr_i == rph_pkg::RPH_A_CMD;
	a_ack_due: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
	a_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h40 |-> wb_dat_o == 32'h0)
		else $error("unmapped read");
	a_flush_tx: assert property (cmd && wb_dat_i[3] |-> ##[1:2] tx_flush_o) else $error("no tx flush");
	a_flush_rx: assert property (cmd && wb_dat_i[4] |-> ##[1:2] rx_flush_o) else $error("no rx flush");
	a_tick_gap: assert property (mod_tick_o |=> !mod_tick_o [*3]) else $error("tick early");
	a_bit_hold: assert property (mod_en_o && $past(mod_en_o) && !mod_tick_o |-> $stable(mod_bit_o))
		else $error("bit moved");
	a_pop_in_tx: assert property (tx_pop_o |-> mod_en_o) else $error("pop outside tx");
	c_pop: cover property (tx_pop_o);
	c_tx_flush: cover property (tx_flush_o);
	c_rx_flush: cover property (rx_flush_o);
endmodule
bind rph_top rph_properties chk (.*);

// [rph_top_bench.sv]
// Self-checking bench for the packet handler
`timescale 1ns/1ps
module rph_top_bench;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, push = 0, dv = 0, db = 0;
	logic ack, pop, tfl, men, mtk, mbit;
	logic [7:0] adr = 0, pd = 0, rssi = 8'h3C, v;
	logic [31:0] dat = 0, rd, wdo;
	int mismatches = 0, compares = 0;
	logic tb[$];
	logic [7:0] rq[$];
	rph_pkg::rph_byte_t head, rxw;
	rph_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(dat), .wb_ack_o(ack), .wb_dat_o(wdo), .tx_byte_i(head), .tx_pop_o(pop),
		.tx_flush_o(tfl), .rx_wr_o(rxw), .rx_flush_o(), .mod_bit_o(mbit), .mod_en_o(men), .mod_tick_o(mtk),
		.dem_bit_i(db), .dem_valid_i(dv), .rssi_i(rssi));
	rph_fifo_model fifo (.clk_i(clk_i), .push_i(push), .data_i(pd), .pop_i(pop), .flush_i(tfl), .head_o(head));
	initial forever #4 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		if (men === 1'b1 && mtk === 1'b1) tb.push_back(mbit);
		if (rxw.valid === 1'b1) rq.push_back(rxw.data);
	end
	task automatic conclude;
		if (mismatches == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, e);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		rd = wdo;
		cyc <= 0;
		stb <= 0;
		@(posedge clk_i);
	endtask
	task automatic wen(input logic lv);
		int n;
		for (n = 0; men !== lv && n < 3000; n++) @(posedge clk_i);
		if (n == 3000) chk(0, 1);
	endtask
	task automatic rxb(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			dv <= 1;
			db <= b[i];
			@(posedge clk_i);
			dv <= 0;
			db <= ~b[i];
			@(posedge clk_i);
		end
	endtask
	initial begin
		static logic [7:0] ra[6] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h40};
		static logic [7:0] rv[6] = '{8'h5A, 8'hFF, 8'h05, 8'h04, 8'h03, 8'h00};
		static logic [7:0] ex[7] = '{8'hAA, 8'h5A, 8'hC3, 8'h5A, 8'hC3, 8'h12, 8'h34};
		static logic [7:0] rs[8] = '{8'hAA, 8'h5A, 8'hC3, 8'h03, 8'h5A, 8'hC3, 8'h01, 8'h7E};
		static logic [7:0] re[4] = '{8'h01, 8'h7E, 8'h3C, 8'h80};
		static logic [7:0] rs2[10] = '{8'hAA, 8'h5A, 8'hC3, 8'h02, 8'h55, 8'h5A, 8'hC3, 8'h02, 8'h00, 8'h7E};
		static logic [7:0] re2[6] = '{8'h02, 8'h02, 8'h00, 8'h7E, 8'h3C, 8'h80};
		repeat (8) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		foreach (ra[i]) begin
			bus(0, ra[i], 0);
			chk(rd, {24'h0, rv[i]});
		end
		bus(1, 8'h2C, 3);
		bus(1, 8'h18, 0);
		bus(1, 8'h1C, 3);
		bus(1, 8'h0C, 0);
		bus(1, 8'h08, 2);
		push <= 1;
		pd <= 8'h12;
		@(posedge clk_i);
		pd <= 8'h34;
		@(posedge clk_i);
		push <= 0;
		bus(1, 8'h24, 1);
		wen(1);
		wen(0);
		for (int k = 0; k < 7; k++) begin
			for (int j = 0; j < 8; j++) v[7 - j] = tb[8 * k + j];
			chk(v, ex[k]);
		end
		bus(0, 8'h28, 0);
		chk(rd[1:0], 0);
		bus(1, 8'h24, 8'h18);
		bus(1, 8'h1C, 2);
		bus(1, 8'h0C, 1);
		bus(1, 8'h24, 2);
		foreach (rs[i]) rxb(rs[i]);
		repeat (10) @(posedge clk_i);
		foreach (re[i]) chk(rq[i], re[i]);
		chk(rq.size(), 4);
		bus(1, 8'h10, 8'h06);
		bus(1, 8'h24, 2);
		foreach (rs2[i]) rxb(rs2[i]);
		repeat (10) @(posedge clk_i);
		foreach (re2[i]) chk(rq[4 + i], re2[i]);
		chk(rq.size(), 10);
		conclude();
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		mismatches++;
		conclude();
	end
endmodule
